// file: reset_clock_startup_sequencer.sv
// Reset and clock start-up sequencer: merges reset causes, drives the
// reset pin, gates CPU and peripheral clocks, prescales the watchdog.
// Assumes the RC clock, oscillator and PLL clocks arrive as levels sampled
// by i_ref_clk, which must run well above all of them.

`default_nettype none

module reset_clock_startup_sequencer
  import startup_pkg::*;
#(
  parameter int unsigned WD_W         = WD_CNT_W,
  parameter int unsigned LONG_HOLD    = LONG_HOLD_CYC,
  parameter int unsigned POR_TIME     = POR_TIMEOUT,
  parameter int unsigned STOP_LONG    = STOP_LONG_CYC,
  parameter int unsigned PIN_LONG_THR = PIN_FLAG_LONG
) (
  input  wire logic       i_ref_clk,
  input  wire logic       i_rst,
  input  wire logic       i_int_rc_clk,
  input  wire logic       i_osc_clk,
  input  wire logic       i_pll_clk,
  input  wire logic [1:0] i_bus_clk_sel,
  input  wire logic       i_power_on_pulse,
  input  wire logic       i_low_voltage_detector,
  input  wire logic       i_monitor_entry_reset,
  input  wire logic       i_illegal_opcode,
  input  wire logic       i_stop_instr,
  input  wire logic       i_stop_enable,
  input  wire logic       i_opcode_fetch,
  input  wire logic       i_unmapped_addr,
  input  wire logic       i_watchdog_service,
  input  wire logic       i_monitor_mode,
  input  wire logic       i_break_state,
  input  wire logic       i_rst_pin_test_high_voltage,
  input  wire logic       i_irq_pin_test_high_voltage,
  input  wire logic       i_wait_mode,
  input  wire logic       i_stop_wake,
  input  wire logic       i_short_recovery_select,
  input  wire logic       i_reset_pin,
  output logic            o_reset_pin_out,
  output logic            o_reset_pin_oe_n,
  output logic            o_internal_reset,
  output logic            o_module_reset,
  output logic            o_cpu_halt,
  output logic [15:0]     o_reset_vector,
  output logic            o_cpu_clk_en,
  output logic            o_periph_clk_en,
  output logic            o_clock_gen_enable,
  output logic            o_bus_clock,
  output logic            o_watchdog_tick,
  output logic [7:0]      o_reset_cause,
  output logic [11:0]     o_stab_counter
);

  typedef enum logic [2:0] {
    ST_RUN,
    ST_LONG_HOLD,
    ST_PIN_DRIVE,
    ST_INTERNAL_RESET_TAIL,
    ST_STOP,
    ST_STOP_REC
  } seq_state_t;

  seq_state_t             state;
  logic [2:0]             rc_sync;
  logic [1:0]             pin_sync;
  logic                   rc_fall;
  logic                   pin_low;
  logic                   ext_low;
  logic [STAB_CNT_W-1:0]  stab_cnt;
  logic                   stab_wrap;
  logic [SEQ_CNT_W-1:0]   seq_cnt;
  logic [SEQ_CNT_W-1:0]   pin_low_cnt;
  logic [SEQ_CNT_W-1:0]   pin_thr;
  logic                   last_long;
  logic [WD_W-1:0]        wd_cnt;
  logic                   wd_disable;
  logic                   wd_overflow;
  logic                   req_long;
  logic                   req_short;
  logic                   req_any;
  logic                   bad_op;
  logic                   bad_addr;
  logic                   stop_ok;
  logic [SEQ_CNT_W-1:0]   stop_len;
  reset_cause_t           cause;
  clk_gate_t              next_gate;
  logic                   next_internal_reset;
  logic                   next_drive;

  // RC clock resynchroniser; stage 0 feeds only stage 1
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      rc_sync <= 3'h0;
    end else begin
      rc_sync <= {rc_sync[1:0], i_int_rc_clk};
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      pin_sync <= 2'h3;
    end else begin
      pin_sync <= {pin_sync[0], i_reset_pin};
    end
  end

  assign rc_fall   = rc_sync[2] & ~rc_sync[1];
  assign pin_low   = ~pin_sync[1];
  // Pin pulled low from outside while running, not our own drive echoing
  assign ext_low   = pin_low && (state == ST_RUN);
  assign stab_wrap = rc_fall && (stab_cnt == {STAB_CNT_W{1'b1}});

  assign bad_op    = i_illegal_opcode | (i_stop_instr & ~i_stop_enable);
  assign stop_ok   = i_stop_instr & i_stop_enable;
  assign bad_addr  = i_opcode_fetch & i_unmapped_addr;

  assign wd_disable = (i_monitor_mode & (i_rst_pin_test_high_voltage
                                         | i_irq_pin_test_high_voltage))
                    | (i_break_state & i_rst_pin_test_high_voltage);
  assign wd_overflow = !wd_disable && stab_wrap && (wd_cnt == {WD_W{1'b1}});

  assign req_long  = i_power_on_pulse | i_low_voltage_detector;
  assign req_short = wd_overflow | bad_op | bad_addr | i_monitor_entry_reset;
  assign req_any   = req_long | req_short;

  assign stop_len  = i_short_recovery_select ?
                     SEQ_CNT_W'(STOP_SHORT_CYC) : SEQ_CNT_W'(STOP_LONG);
  assign pin_thr   = last_long ? SEQ_CNT_W'(PIN_LONG_THR)
                               : SEQ_CNT_W'(PIN_FLAG_SHORT);

  // Stabilisation counter
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      stab_cnt <= '0;
    end else if (req_any || (stop_ok && state == ST_RUN)) begin
      stab_cnt <= '0;
    end else if (i_watchdog_service) begin
      stab_cnt[SVC_CLR_HI:SVC_CLR_LO] <= '0;
      if (rc_fall) begin
        stab_cnt[SVC_CLR_LO-1:0] <= stab_cnt[SVC_CLR_LO-1:0] + 1'b1;
      end
    end else if (rc_fall) begin
      stab_cnt <= stab_cnt + 1'b1;
    end
  end

  // Watchdog counter
  always_ff @(posedge i_ref_clk) begin
    if (i_rst || o_internal_reset || i_watchdog_service || wd_disable) begin
      wd_cnt <= '0;
    end else if (stab_wrap) begin
      wd_cnt <= wd_cnt + 1'b1;
    end
  end

  // Sequencer state and phase counter
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      state   <= ST_LONG_HOLD;
      seq_cnt <= '0;
    end else if (req_long) begin
      state   <= ST_LONG_HOLD;
      seq_cnt <= '0;
    end else if (req_short) begin
      state   <= ST_PIN_DRIVE;
      seq_cnt <= '0;
    end else begin
      unique case (state)
        ST_RUN: begin
          seq_cnt <= '0;
          if (stop_ok) begin
            state <= ST_STOP;
          end
        end
        ST_LONG_HOLD: begin
          if (rc_fall) begin
            if (seq_cnt == SEQ_CNT_W'(LONG_HOLD - 1)) begin
              state   <= ST_INTERNAL_RESET_TAIL;
              seq_cnt <= '0;
            end else begin
              seq_cnt <= seq_cnt + 1'b1;
            end
          end
        end
        ST_PIN_DRIVE: begin
          if (rc_fall) begin
            if (seq_cnt == SEQ_CNT_W'(PIN_DRIVE_CYC - 1)) begin
              state   <= ST_INTERNAL_RESET_TAIL;
              seq_cnt <= '0;
            end else begin
              seq_cnt <= seq_cnt + 1'b1;
            end
          end
        end
        ST_INTERNAL_RESET_TAIL: begin
          if (rc_fall) begin
            if (seq_cnt == SEQ_CNT_W'(INTERNAL_RESET_TAIL_CYC - 1)) begin
              state   <= ST_RUN;
              seq_cnt <= '0;
            end else begin
              seq_cnt <= seq_cnt + 1'b1;
            end
          end
        end
        ST_STOP: begin
          seq_cnt <= '0;
          // exit by interrupt, break or reset
          if (i_stop_wake || pin_low) begin
            state <= ST_STOP_REC;
          end
        end
        ST_STOP_REC: begin
          if (rc_fall) begin
            if (seq_cnt == stop_len - 1'b1) begin
              state   <= ST_RUN;
              seq_cnt <= '0;
            end else begin
              seq_cnt <= seq_cnt + 1'b1;
            end
          end
        end
      endcase
    end
  end

  // Pin low duration for the pin cause flag
  always_ff @(posedge i_ref_clk) begin
    if (i_rst || !pin_low) begin
      pin_low_cnt <= '0;
    end else if (rc_fall && pin_low_cnt != {SEQ_CNT_W{1'b1}}) begin
      pin_low_cnt <= pin_low_cnt + 1'b1;
    end
  end

  // Remembers whether the latest reset used the long sequence
  always_ff @(posedge i_ref_clk) begin
    if (i_rst || req_long) begin
      last_long <= 1'b1;
    end else if (req_short) begin
      last_long <= 1'b0;
    end
  end

  // Reset cause flags; a power-on pulse clears all but the power-on flag, which it sets, and wins over any new event
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      cause <= CAUSE_RESET;
    end else if (i_power_on_pulse) begin
      cause <= CAUSE_RESET;
    end else begin
      if (wd_overflow) begin
        cause.watchdog <= 1'b1;
      end
      if (bad_op) begin
        cause.bad_opcode_flag <= 1'b1;
      end
      if (bad_addr) begin
        cause.bad_address_flag <= 1'b1;
      end
      if (i_low_voltage_detector) begin
        cause.low_voltage <= 1'b1;
      end
      if (pin_low && pin_low_cnt >= pin_thr) begin
        cause.pin <= 1'b1;
      end
    end
  end

  // Next values of the pin, reset and clock gate outputs
  always_comb begin
    next_internal_reset  = 1'b0;
    next_drive = 1'b0;
    next_gate  = '{cpu_en: 1'b1, periph_en: 1'b1};
    unique case (state)
      ST_RUN: begin
        next_gate.cpu_en = ~i_wait_mode;
        next_internal_reset        = ext_low;
      end
      ST_LONG_HOLD: begin
        next_internal_reset  = 1'b1;
        next_drive = 1'b1;
        next_gate.cpu_en    = (seq_cnt >= SEQ_CNT_W'(POR_TIME));
        next_gate.periph_en = (seq_cnt >= SEQ_CNT_W'(POR_TIME));
      end
      ST_PIN_DRIVE: begin
        next_internal_reset  = 1'b1;
        next_drive = 1'b1;
        next_gate  = '{cpu_en: 1'b0, periph_en: 1'b0};
      end
      ST_INTERNAL_RESET_TAIL: begin
        next_internal_reset  = 1'b1;
        next_gate  = '{cpu_en: last_long, periph_en: last_long};
      end
      ST_STOP, ST_STOP_REC: begin
        next_gate = '{cpu_en: 1'b0, periph_en: 1'b0};
      end
    endcase
    if (req_any) begin
      next_internal_reset  = 1'b1;
      next_drive = 1'b1;
      next_gate  = '{cpu_en: 1'b0, periph_en: 1'b0};
    end
  end

  // Registered reset and pin outputs
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_internal_reset <= 1'b1;
      o_module_reset   <= 1'b1;
      o_reset_pin_out  <= 1'b0;
      o_reset_pin_oe_n <= 1'b0;
      o_cpu_halt       <= 1'b1;
    end else begin
      o_internal_reset <= next_internal_reset;
      o_module_reset   <= next_internal_reset;
      o_reset_pin_out  <= 1'b0;
      o_reset_pin_oe_n <= ~next_drive;
      o_cpu_halt       <= next_internal_reset | pin_low;
    end
  end

  // Registered clock gates, vector and status outputs
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_cpu_clk_en    <= 1'b0;
      o_periph_clk_en <= 1'b0;
      o_reset_vector  <= VEC_USER;
      o_watchdog_tick <= 1'b0;
      o_reset_cause   <= CAUSE_RESET;
      o_stab_counter  <= '0;
    end else begin
      // Our own pin drive echoes back and must not stop the clocks
      o_cpu_clk_en    <= next_gate.cpu_en & ~ext_low;
      o_periph_clk_en <= next_gate.periph_en & ~ext_low;
      o_reset_vector  <= i_monitor_mode ? VEC_MONITOR : VEC_USER;
      o_watchdog_tick <= stab_wrap;
      o_reset_cause   <= cause;
      o_stab_counter  <= stab_cnt;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_clock_gen_enable <= 1'b0;
    end else if (i_power_on_pulse) begin
      o_clock_gen_enable <= 1'b1;
    end
  end

  bus_clock_divider u_bus_div (
    .i_ref_clk   (i_ref_clk),
    .i_rst       (i_rst),
    .i_enable    (o_clock_gen_enable),
    .i_sel       (i_bus_clk_sel),
    .i_osc_clk   (i_osc_clk),
    .i_pll_clk   (i_pll_clk),
    .o_bus_clock (o_bus_clock)
  );

endmodule

`default_nettype wire

// file: startup_support.sv
// Constants, types and the bus clock divider of the start-up sequencer.
// Assumes every input is synchronous to i_ref_clk; slow clocks arrive as
// sampled levels and are resynchronised before their edges are used.

`default_nettype none

package startup_pkg;

  // Counter and sequence widths
  localparam int unsigned STAB_CNT_W     = 12;
  localparam int unsigned SEQ_CNT_W      = 13;
  localparam int unsigned WD_CNT_W       = 8;

  // Sequence durations in internal RC clock cycles
  localparam int unsigned POR_TIMEOUT    = 4096;
  localparam int unsigned PIN_DRIVE_CYC  = 32;
  localparam int unsigned INTERNAL_RESET_TAIL_CYC  = 32;
  localparam int unsigned LONG_HOLD_CYC  = POR_TIMEOUT + PIN_DRIVE_CYC;
  localparam int unsigned STOP_LONG_CYC  = 4096;
  localparam int unsigned STOP_SHORT_CYC = 32;
  localparam int unsigned PIN_FLAG_SHORT = 67;
  localparam int unsigned PIN_FLAG_LONG  = 4163;

  // Service write clears counter bits 12..5, counted from one
  localparam int unsigned SVC_CLR_HI     = 11;
  localparam int unsigned SVC_CLR_LO     = 4;

  // Reset vectors
  localparam logic [15:0] VEC_USER       = 16'hFFFE;
  localparam logic [15:0] VEC_MONITOR    = 16'hFEFE;

  // Bus clock source selections
  localparam logic [1:0]  SEL_OSC_DIV4   = 2'h0;
  localparam logic [1:0]  SEL_OSC_DIV2   = 2'h1;
  localparam logic [1:0]  SEL_PLL_DIV4   = 2'h2;

  // Reset cause register layout, bit 7 down to bit 0
  typedef struct packed {
    logic power_on;
    logic pin;
    logic watchdog;
    logic bad_opcode_flag;
    logic bad_address_flag;
    logic zero2;
    logic low_voltage;
    logic zero0;
  } reset_cause_t;

  localparam reset_cause_t CAUSE_RESET = 8'h80;

  // Clock gating outputs
  typedef struct packed {
    logic cpu_en;
    logic periph_en;
  } clk_gate_t;

endpackage

// Derives the bus clock from the selected sampled source clock.
module bus_clock_divider
  import startup_pkg::*;
(
  input  wire logic       i_ref_clk,
  input  wire logic       i_rst,
  input  wire logic       i_enable,
  input  wire logic [1:0] i_sel,
  input  wire logic       i_osc_clk,
  input  wire logic       i_pll_clk,
  output logic            o_bus_clock
);

  logic [2:0] osc_sync;
  logic [2:0] pll_sync;
  logic       src_rise;
  logic       half_cnt;

  // Two-flop synchronisers plus an edge history stage
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      osc_sync <= 3'h0;
      pll_sync <= 3'h0;
    end else begin
      osc_sync <= {osc_sync[1:0], i_osc_clk};
      pll_sync <= {pll_sync[1:0], i_pll_clk};
    end
  end

  assign src_rise = (i_sel == SEL_PLL_DIV4) ? (pll_sync[1] & ~pll_sync[2])
                                            : (osc_sync[1] & ~osc_sync[2]);

  always_ff @(posedge i_ref_clk) begin
    if (i_rst || !i_enable) begin
      half_cnt    <= 1'b0;
      o_bus_clock <= 1'b0;
    end else if (src_rise) begin
      if (i_sel == SEL_OSC_DIV2 || half_cnt) begin
        half_cnt    <= 1'b0;
        o_bus_clock <= ~o_bus_clock;
      end else begin
        half_cnt    <= 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

// file: ext_reset_circuit.sv
// Far side of the reset pin: board pull-up plus an external pull-down.
// Assumes the block's pin enable is low while it drives its pin value.
`default_nettype none
module ext_reset_circuit (
  input  wire logic i_hold_low,
  input  wire logic i_oe_n,
  input  wire logic i_drive,
  output logic      o_pad
);
  timeunit 1ns;
  timeprecision 1ps;
  // Wired pad: any party pulling low wins, released pin floats high
  // external low level
  assign o_pad = !(i_hold_low || (!i_oe_n && !i_drive));
endmodule
`default_nettype wire

// file: startup_seq_sva.sv
// Checker for the start-up sequencer, bound to its top module.
// Assumes the synchronous active-high reset and the package constants.
`default_nettype none
module startup_seq_sva (
  input wire logic        i_ref_clk,
  input wire logic        i_rst,
  input wire logic        i_power_on_pulse,
  input wire logic        i_monitor_entry_reset,
  input wire logic        i_illegal_opcode,
  input wire logic        i_stop_instr,
  input wire logic        i_stop_enable,
  input wire logic        i_opcode_fetch,
  input wire logic        i_unmapped_addr,
  input wire logic        i_watchdog_service,
  input wire logic        i_reset_pin,
  input wire logic        o_reset_pin_oe_n,
  input wire logic        o_internal_reset,
  input wire logic        o_module_reset,
  input wire logic        o_cpu_halt,
  input wire logic        o_cpu_clk_en,
  input wire logic        o_periph_clk_en,
  input wire logic        o_watchdog_tick,
  input wire logic [7:0]  o_reset_cause,
  input wire logic [11:0] o_stab_counter
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  // Reset causes take effect on the next cycle
  property p_bad_op;
    i_illegal_opcode |=> o_internal_reset && !o_reset_pin_oe_n;
  endproperty
  a_bad_op: assert property (p_bad_op)
    else $error("bad opcode no reset");
  property p_stop_ill;
    i_stop_instr && !i_stop_enable |=> o_internal_reset;
  endproperty
  a_stop_ill: assert property (p_stop_ill)
    else $error("stop not refused");
  property p_bad_addr;
    i_opcode_fetch && i_unmapped_addr |=> o_internal_reset;
  endproperty
  a_bad_addr: assert property (p_bad_addr)
    else $error("bad fetch no reset");
  property p_mon_rst;
    i_monitor_entry_reset |=> !o_reset_pin_oe_n;
  endproperty
  a_mon_rst: assert property (p_mon_rst)
    else $error("pin not driven");
  // Pin is driven only inside an internal reset
  property p_pin_internal_reset;
    !o_reset_pin_oe_n |-> o_internal_reset;
  endproperty
  a_pin_internal_reset: assert property (p_pin_internal_reset)
    else $error("pin without reset");
  property p_mod_rst;
    o_internal_reset |-> o_module_reset && o_cpu_halt;
  endproperty
  a_mod_rst: assert property (p_mod_rst)
    else $error("modules not reset");
  property p_clks;
    o_cpu_clk_en |-> o_periph_clk_en;
  endproperty
  a_clks: assert property (p_clks)
    else $error("cpu clock alone");
  // Flag path: two synchroniser stages, flag, output register
  property p_pin_flag;
    $rose(o_reset_cause[6]) |-> !$past(i_reset_pin, 4);
  endproperty
  a_pin_flag: assert property (p_pin_flag)
    else $error("pin flag, pin high");
  property p_por;
    i_power_on_pulse |-> ##2 o_reset_cause == 8'h80;
  endproperty
  a_por: assert property (p_por)
    else $error("power-on cause wrong");
  // Gates drop one cycle after the state enters stop
  property p_stop;
    i_stop_instr && i_stop_enable && o_cpu_clk_en && !o_internal_reset
      |=> ##1 (!o_cpu_clk_en && !o_periph_clk_en) ##[0:2]
          o_stab_counter == 0;
  endproperty
  a_stop: assert property (p_stop)
    else $error("stop entry wrong");
  property p_service;
    i_watchdog_service |-> ##[1:3] o_stab_counter[11:4] == 8'h00;
  endproperty
  a_service: assert property (p_service)
    else $error("service no clear");
  property p_tick;
    o_watchdog_tick |=> !o_watchdog_tick [*8];
  endproperty
  a_tick: assert property (p_tick)
    else $error("tick too long");
  // Main scenarios reached
  c_tick: cover property (o_watchdog_tick);
  c_pin: cover property ($rose(o_reset_cause[6]));
  c_stop: cover property ($fell(o_periph_clk_en));
endmodule
bind reset_clock_startup_sequencer startup_seq_sva startup_seq_sva_inst (
  .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_power_on_pulse(i_power_on_pulse),
  .i_monitor_entry_reset(i_monitor_entry_reset),
  .i_illegal_opcode(i_illegal_opcode), .i_stop_instr(i_stop_instr),
  .i_stop_enable(i_stop_enable), .i_opcode_fetch(i_opcode_fetch),
  .i_unmapped_addr(i_unmapped_addr), .i_watchdog_service(i_watchdog_service),
  .i_reset_pin(i_reset_pin), .o_reset_pin_oe_n(o_reset_pin_oe_n),
  .o_internal_reset(o_internal_reset), .o_module_reset(o_module_reset),
  .o_cpu_halt(o_cpu_halt), .o_cpu_clk_en(o_cpu_clk_en),
  .o_periph_clk_en(o_periph_clk_en), .o_watchdog_tick(o_watchdog_tick),
  .o_reset_cause(o_reset_cause), .o_stab_counter(o_stab_counter));
`default_nettype wire

// file: tb_reset_clock_startup_sequencer.sv
// Testbench for the start-up sequencer: resets, wait, stop, pin, clocks.
// Assumes slow clocks as levels sampled by the 125 MHz reference clock.
`default_nettype none
module tb_reset_clock_startup_sequencer import startup_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LH = 40;
  localparam logic [7:0] CT [6] = '{8'h80, 8'h82, 8'h82, 8'h92, 8'h92, 8'h9A};
  localparam int BT [4] = '{20, 40, 12, 20};
  logic clk, rst, rc, osc, pll, pwr, lvd, mer, bad_op, stp, stp_en, opf;
  logic unm, svc, mon, brk, rtv, itv, wt, wake, ssr, ext_low, pad;
  logic pout, oe_n, ires, mres, halt, cpu_en, per_en, cg_en, bclk, tick;
  logic [1:0] sel;
  logic [15:0] vec;
  logic [7:0] cause;
  logic [11:0] cnt;
  int err_count = 0;
  int n_checks = 0;
  int rc_falls = 0;
  int ticks = 0;
  int ph = 0;

  reset_clock_startup_sequencer #(.WD_W(2), .LONG_HOLD(LH), .POR_TIME(8),
    .STOP_LONG(16), .PIN_LONG_THR(60)) reset_clock_startup_sequencer_inst (
    .i_ref_clk(clk), .i_rst(rst), .i_int_rc_clk(rc), .i_osc_clk(osc),
    .i_pll_clk(pll), .i_bus_clk_sel(sel), .i_power_on_pulse(pwr),
    .i_low_voltage_detector(lvd), .i_monitor_entry_reset(mer),
    .i_illegal_opcode(bad_op), .i_stop_instr(stp), .i_stop_enable(stp_en),
    .i_opcode_fetch(opf), .i_unmapped_addr(unm), .i_watchdog_service(svc),
    .i_monitor_mode(mon), .i_break_state(brk),
    .i_rst_pin_test_high_voltage(rtv), .i_irq_pin_test_high_voltage(itv),
    .i_wait_mode(wt), .i_stop_wake(wake), .i_short_recovery_select(ssr),
    .i_reset_pin(pad), .o_reset_pin_out(pout), .o_reset_pin_oe_n(oe_n),
    .o_internal_reset(ires), .o_module_reset(mres), .o_cpu_halt(halt),
    .o_reset_vector(vec), .o_cpu_clk_en(cpu_en), .o_periph_clk_en(per_en),
    .o_clock_gen_enable(cg_en), .o_bus_clock(bclk), .o_watchdog_tick(tick),
    .o_reset_cause(cause), .o_stab_counter(cnt));
  ext_reset_circuit ext_reset_circuit_inst (.i_hold_low(ext_low),
    .i_oe_n(oe_n), .i_drive(pout), .o_pad(pad));

  // Reference clock
  initial begin
    clk = 0;
    forever #4 clk = ~clk;
  end
  // Slow clocks as levels, moved just after each edge; falls and ticks
  always @(posedge clk) begin
    #1;
    ph = ph + 1;
    rc = ph[2];
    osc = (ph % 6) < 3;
    pll = (ph % 10) < 5;
    if (ph % 8 == 0) rc_falls = rc_falls + 1;
    if (tick === 1'b1) ticks = ticks + 1;
  end

  task wrap_up;
    if (err_count == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task step(input int n);
    repeat (n) begin
      @(posedge clk);
      #1;
    end
  endtask
  task check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  function automatic logic [15:0] near(input int f, input int n);
    return 16'(f >= n - 2 && f <= n + 2);
  endfunction
  // Bounded wait for a level on oe_n, reset, cpu clock or halt
  task wait_until(input int w, input logic v, output int f);
    int n0;
    logic s;
    n0 = rc_falls;
    for (int k = 0; k < 40000; k++) begin
      s = (w == 0) ? oe_n : (w == 1) ? ires : (w == 2) ? cpu_en : halt;
      if (s === v) break;
      step(1);
    end
    f = rc_falls - n0;
    if (s !== v) begin
      err_count++;
      wrap_up();
    end
  endtask
  // One-cycle pulse on a reset source, in table order
  task pulse(input int w);
    case (w)
      0: pwr = 1;
      1: lvd = 1;
      2: mer = 1;
      3: bad_op = 1;
      4: {stp, stp_en} = 2'b10;
      default: {opf, unm} = 2'b11;
    endcase
    step(1);
    {pwr, lvd, mer, bad_op, stp, opf, unm} = '0;
    stp_en = 1;
  endtask
  // Pin phase, tail phase, then run with sticky causes
  task seq(input logic lng, input logic [7:0] exp_cause);
    int f;
    check(16'(ires), 16'h1);
    check(16'(cpu_en), 16'h0);
    wait_until(0, 1'b1, f);
    check(near(f, lng ? LH : 32), 16'h1);
    check(16'(cpu_en), 16'(lng));
    wait_until(1, 1'b0, f);
    check(near(f, 32), 16'h1);
    check(16'({cpu_en, halt, mres}), 16'h4);
    step(2);
    check(16'(cause), 16'(exp_cause));
    check(vec, mon ? VEC_MONITOR : VEC_USER);
    check(16'(cg_en), 16'h1);
  endtask
  task s_wait;
    unm = 1;
    wt = 1;
    step(2);
    check(16'({ires, cpu_en, per_en}), 16'h1);
    {unm, wt} = 2'b00;
    step(2);
    check(16'({cpu_en, per_en}), 16'h3);
  endtask
  task s_stop(input logic sr);
    int f;
    ssr = sr;
    stp = 1;
    step(1);
    stp = 0;
    step(2);
    check(16'({cpu_en, per_en, cnt[11:4]}), 16'h0);
    wake = 1;
    step(1);
    wake = 0;
    wait_until(2, 1'b1, f);
    check(near(f, sr ? 32 : 16), 16'h1);
  endtask
  task s_pin;
    int f0, f;
    logic [11:0] c0, d;
    c0 = cnt;
    f0 = rc_falls;
    ext_low = 1;
    step(3);
    check(16'({halt, ires}), 16'h3);
    step(8 * 60);
    check(16'(cause[6]), 16'h0);
    step(8 * 10);
    check(16'(cause[6]), 16'h1);
    d = cnt - c0;
    check(near(int'(d), rc_falls - f0), 16'h1);
    ext_low = 0;
    wait_until(3, 1'b0, f);
  endtask
  task s_service_bus;
    int t;
    logic b;
    svc = 1;
    step(1);
    svc = 0;
    step(1);
    check(16'(cnt[11:4]), 16'h0);
    for (int s = 0; s < 4; s++) begin
      sel = 2'(s);
      step(8);
      t = 0;
      b = bclk;
      repeat (240) begin
        step(1);
        if (bclk !== b) t++;
        b = bclk;
      end
      check(near(t, BT[s]), 16'h1);
    end
  endtask

  // Main sequence
  initial begin
    {rc, osc, pll, pwr, lvd, mer, bad_op, stp, opf, unm, svc} = '0;
    {mon, brk, rtv, itv, wt, wake, ssr, ext_low, sel} = '0;
    stp_en = 1;
    rst = 1;
    step(2);
    rst = 0;
    check({oe_n, cause, 7'h00}, 16'h4000);
    check(vec, VEC_USER);
    for (int i = 0; i < 6; i++) begin
      mon = (i == 2);
      pulse(i);
      seq(i < 2, CT[i]);
    end
    mon = 0;
    s_wait();
    s_stop(1'b1);
    s_stop(1'b0);
    s_pin();
    s_service_bus();
    {mon, rtv} = 2'b11;
    step(8 * 4100);
    check(16'({ticks > 0, ires}), 16'h2);
    wrap_up();
  end
endmodule
`default_nettype wire
